/* hdl/llc_pkg.sv */
/*
 * llc_pkg: register map, field layout, reset values and carrier types for
 * the line-lock detector and clamp gain register bank.
 * Assumes a single system clock and a host on the two-wire control bus.
 */
//
// Notes on behaviour
// R1 - lock is lost after 4 x loss-field consecutive lines above threshold
// R2 - lock is gained after 4 x acquire-field consecutive lines below threshold
// R3 - one threshold, limit field times 8 samples, serves gain and loss
// R4 - proportional gain divides by 64, 32, 16, 8 for codes 00..11
// R5 - integral gain code 000 divides by 64, code 111 by 5192
// R6 - derivative selector code 00 gives a factor of one
// R7 - host writes fixed patterns into the fully reserved tuning registers
// R8 - host keeps limit bits 5:4 at 01 and clamp bit 3 at 0
// R9 - host writes 0x0A to tuning d and all zeros to tuning e
// R10 - any line breaking the pending condition restarts the run counter
// R11 - lock indication changes only when a full run completes
package llc_pkg;

	localparam logic [7:0] OFS_TUNING_A  = 8'h1E;
	localparam logic [7:0] OFS_LOCK_RUNS = 8'h28;
	localparam logic [7:0] OFS_LIMIT     = 8'h29;
	localparam logic [7:0] OFS_CLAMP     = 8'h2A;
	localparam logic [7:0] OFS_TUNING_B  = 8'h2B;
	localparam logic [7:0] OFS_TUNING_C  = 8'h2C;
	localparam logic [7:0] OFS_TUNING_D  = 8'h2D;
	localparam logic [7:0] OFS_TUNING_E  = 8'h2E;
	localparam logic [7:0] OFS_STATUS    = 8'h40;

	localparam logic [7:0] RST_TUNING_A  = 8'h66;
	localparam logic [7:0] RST_LOCK_RUNS = 8'h82;
	localparam logic [7:0] RST_LIMIT     = 8'h55;
	localparam logic [7:0] RST_CLAMP     = 8'h82;
	localparam logic [7:0] RST_TUNING_B  = 8'h63;
	localparam logic [7:0] RST_TUNING_C  = 8'h82;
	localparam logic [7:0] RST_TUNING_D  = 8'h0A;
	localparam logic [7:0] RST_TUNING_E  = 8'h00;

	// field positions
	localparam int LOSS_RUN_LSB = 4;
	localparam int ACQ_RUN_LSB  = 0;
	localparam int LIMIT_LSB    = 0;
	localparam int P_SEL_LSB    = 6;
	localparam int D_SEL_LSB    = 4;
	localparam int I_SEL_LSB    = 0;

	// run and threshold scaling
	localparam int RUN_SHIFT   = 2;
	localparam int LIMIT_SHIFT = 3;

	// integral divisors
	localparam logic [12:0] I_DIV_MIN = 13'h0040;
	localparam logic [12:0] I_DIV_MAX = 13'h1448;

	// arbitrary bus address of this device
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C;

	typedef struct packed {
		logic [3:0] loss_run;
		logic [3:0] acq_run;
		logic [3:0] limit;
	} llc_lock_cfg_t;

endpackage : llc_pkg

/* hdl/llc_pin_sync.sv */
/*
 * llc_pin_sync: three-stage input synchroniser; the output follows the pin
 * once the second and third stages agree.
 * Assumes the pin is asynchronous to MCLK.
 */
`timescale 1ns/1ps
`default_nettype none
module llc_pin_sync
	import llc_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output var  logic level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1    <= RESET_LEVEL;
			s2    <= RESET_LEVEL;
			s3    <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule : llc_pin_sync
`default_nettype wire

/* hdl/llc_lock_detect.sv */
/*
 * llc_lock_detect: per-line phase error hysteresis lock detector.
 * Assumes line_done is a one-cycle pulse with phase_err valid alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module llc_lock_detect
	import llc_pkg::*;
#(
	parameter int PHASE_W = 8
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               line_done,
	input  wire logic [PHASE_W-1:0] phase_err,
	input  wire llc_lock_cfg_t      cfg,
	output var  logic               locked,
	output var  logic               gained,
	output var  logic               lost
);
	wire [7:0]  threshold  = {1'b0, cfg.limit, 3'h0};                       // [R3]
	wire [5:0]  need_acq   = {cfg.acq_run, 2'h0};                           // [R2]
	wire [5:0]  need_loss  = {cfg.loss_run, 2'h0};                          // [R1]
	wire [8:0]  err_ext    = 9'(phase_err);
	wire        below      = err_ext < {1'b0, threshold};                   // [R3]
	wire        above      = err_ext > {1'b0, threshold};                   // [R3]
	wire        run_ok     = locked ? above : below;
	wire [5:0]  need       = locked ? need_loss : need_acq;
	logic [5:0] run;
	wire [6:0]  next_run   = {1'b0, run} + 7'h01;
	wire        run_done   = next_run >= {1'b0, need};

	always_ff @(posedge clk) begin
		if (rst) begin
			run    <= 6'h00;
			locked <= 1'b0;
			gained <= 1'b0;
			lost   <= 1'b0;
		end else begin
			gained <= 1'b0;
			lost   <= 1'b0;
			if (line_done) begin
				if (!run_ok) begin
					run <= 6'h00;                                           // [R10]
				end else if (run_done) begin
					run    <= 6'h00;
					locked <= !locked;                                      // [R11] [R1] [R2]
					gained <= !locked;
					lost   <= locked;
				end else begin
					run <= next_run[5:0];
				end
			end
		end
	end
endmodule : llc_lock_detect
`default_nettype wire

/* hdl/llc_top.sv */
/*
 * llc_top: two-wire bus slave, register bank, line-lock detector and clamp
 * gain decode.
 * Assumes open-drain SCL/SDA resolved outside, and line_done/phase_err
 * produced on MCLK by the line-locked loop.
 */
`timescale 1ns/1ps
`default_nettype none
module llc_top
	import llc_pkg::*;
#(
	parameter int         PHASE_W  = 8,
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
	input  wire logic               MCLK,
	input  wire logic               RST,
	input  wire logic               SCL_IN,
	input  wire logic               SDA_IN,
	output var  logic               SDA_OUT,
	output var  logic               SDA_OE,
	input  wire logic               LINE_DONE,
	input  wire logic [PHASE_W-1:0] PHASE_ERR,
	output var  logic               LINE_LOCKED,
	output var  logic               LOCK_GAINED,
	output var  logic               LOCK_LOST,
	output var  logic [2:0]         CLAMP_P_SHIFT,
	output var  logic [12:0]        CLAMP_I_DIVISOR,
	output var  logic [2:0]         CLAMP_D_FACTOR
);
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_ADDR     = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_SUB      = 9'h008,
		ST_SUB_ACK  = 9'h010,
		ST_WDATA    = 9'h020,
		ST_WACK     = 9'h040,
		ST_RDATA    = 9'h080,
		ST_RACK     = 9'h100
	} llc_bus_state_t;

	// register bank
	logic [7:0] tuning_a;
	logic [7:0] lock_runs;
	logic [7:0] limit_reg;
	logic [7:0] clamp_reg;
	logic [7:0] tuning_b;
	logic [7:0] tuning_c;
	logic [7:0] tuning_d;
	logic [7:0] tuning_e;

	// bus slave state
	llc_bus_state_t state;
	logic [3:0]     bit_cnt;
	logic [7:0]     shift;
	logic [7:0]     tx;
	logic [7:0]     ptr;
	logic           rd_mode;
	logic           nack;
	logic           scl_prev;
	logic           sda_prev;
	logic           scl_s;
	logic           sda_s;

	llc_pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
		.clk   (MCLK),
		.rst   (RST),
		.pin   (SCL_IN),
		.level (scl_s)
	);

	llc_pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
		.clk   (MCLK),
		.rst   (RST),
		.pin   (SDA_IN),
		.level (sda_s)
	);

	llc_lock_cfg_t lock_cfg;
	assign lock_cfg.loss_run = lock_runs[LOSS_RUN_LSB +: 4];
	assign lock_cfg.acq_run  = lock_runs[ACQ_RUN_LSB +: 4];
	assign lock_cfg.limit    = limit_reg[LIMIT_LSB +: 4];

	llc_lock_detect #(.PHASE_W(PHASE_W)) u_lock (
		.clk       (MCLK),
		.rst       (RST),
		.line_done (LINE_DONE),
		.phase_err (PHASE_ERR),
		.cfg       (lock_cfg),
		.locked    (LINE_LOCKED),
		.gained    (LOCK_GAINED),
		.lost      (LOCK_LOST)
	);

	// bus events
	wire scl_rise  = scl_s && !scl_prev;
	wire scl_fall  = !scl_s && scl_prev;
	wire start_cnd = scl_s && scl_prev && sda_prev && !sda_s;
	wire stop_cnd  = scl_s && scl_prev && !sda_prev && sda_s;
	wire byte_done = bit_cnt == 4'h8;
	wire addr_hit  = shift[7:1] == DEV_ADDR;
	wire [7:0] ptr_inc = ptr + 8'h01;

	// one write strobe per received data byte
	wire wr_en   = (state == ST_WDATA) && scl_fall && byte_done;
	wire load_tx = scl_fall && (((state == ST_ADDR_ACK) && rd_mode) ||
		((state == ST_RACK) && !nack));

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			OFS_TUNING_A:  reg_read = tuning_a;
			OFS_LOCK_RUNS: reg_read = lock_runs;
			OFS_LIMIT:     reg_read = limit_reg;
			OFS_CLAMP:     reg_read = clamp_reg;
			OFS_TUNING_B:  reg_read = tuning_b;
			OFS_TUNING_C:  reg_read = tuning_c;
			OFS_TUNING_D:  reg_read = tuning_d;
			OFS_TUNING_E:  reg_read = tuning_e;
			OFS_STATUS:    reg_read = {7'h00, LINE_LOCKED};
			default:       reg_read = 8'h00;
		endcase
	endfunction : reg_read

	wire [7:0] rd_data = reg_read(ptr);

	// pointer: loaded from the subaddress, stepped once per byte moved
	// wraps from FF to 00; unmapped offsets read as zero
	wire sub_load = scl_fall && (state == ST_SUB) && byte_done;
	wire ptr_step = load_tx || wr_en;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ptr <= 8'h00;
		end else if (sub_load) begin
			ptr <= shift;
		end else if (ptr_step) begin
			ptr <= ptr_inc;
		end
	end

	// read byte, latched as its first bit goes out
	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx <= 8'h00;
		end else if (load_tx) begin
			tx <= rd_data;
		end
	end

	// bus slave sequencing
	always_ff @(posedge MCLK) begin
		if (RST) begin
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			shift    <= 8'h00;
			rd_mode  <= 1'b0;
			nack     <= 1'b0;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			SDA_OE   <= 1'b0;
			SDA_OUT  <= 1'b0;
		end else begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
			SDA_OUT  <= 1'b0;
			if (start_cnd) begin
				state   <= ST_ADDR;
				bit_cnt <= 4'h0;
				SDA_OE  <= 1'b0;
			end else if (stop_cnd) begin
				state  <= ST_IDLE;
				SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_SUB, ST_WDATA: begin
						shift   <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_RDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_RACK: begin
						nack <= sda_s;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (byte_done) begin
							if (addr_hit) begin
								state   <= ST_ADDR_ACK;
								rd_mode <= shift[0];
								SDA_OE  <= 1'b1;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt <= 4'h0;
						if (rd_mode) begin
							state  <= ST_RDATA;
							SDA_OE <= !rd_data[7];
						end else begin
							state  <= ST_SUB;
							SDA_OE <= 1'b0;
						end
					end
					ST_SUB: begin
						if (byte_done) begin
							state  <= ST_SUB_ACK;
							SDA_OE <= 1'b1;
						end
					end
					ST_SUB_ACK, ST_WACK: begin
						state   <= ST_WDATA;
						bit_cnt <= 4'h0;
						SDA_OE  <= 1'b0;
					end
					ST_WDATA: begin
						if (byte_done) begin
							state  <= ST_WACK;
							SDA_OE <= 1'b1;
						end
					end
					ST_RDATA: begin
						if (byte_done) begin
							state  <= ST_RACK;
							SDA_OE <= 1'b0;
						end else begin
							SDA_OE <= !tx[3'(7 - bit_cnt)];
						end
					end
					ST_RACK: begin
						if (nack) begin
							state  <= ST_IDLE;
							SDA_OE <= 1'b0;
						end else begin
							state   <= ST_RDATA;
							bit_cnt <= 4'h0;
							SDA_OE  <= !rd_data[7];
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// register writes; host supplies the reserved patterns
	always_ff @(posedge MCLK) begin
		if (RST) begin
			tuning_a  <= RST_TUNING_A;
			lock_runs <= RST_LOCK_RUNS;
			limit_reg <= RST_LIMIT;
			clamp_reg <= RST_CLAMP;
			tuning_b  <= RST_TUNING_B;
			tuning_c  <= RST_TUNING_C;
			tuning_d  <= RST_TUNING_D;
			tuning_e  <= RST_TUNING_E;
		end else if (wr_en) begin
			case (ptr)
				OFS_TUNING_A:  tuning_a  <= shift;                         // [R7]
				OFS_LOCK_RUNS: lock_runs <= shift;
				OFS_LIMIT:     limit_reg <= shift;                         // [R8]
				OFS_CLAMP:     clamp_reg <= shift;                         // [R8]
				OFS_TUNING_B:  tuning_b  <= shift;                         // [R7]
				OFS_TUNING_C:  tuning_c  <= shift;                         // [R7]
				OFS_TUNING_D:  tuning_d  <= shift;                         // [R9]
				OFS_TUNING_E:  tuning_e  <= shift;                         // [R9]
				default: begin
				end
			endcase
		end
	end

	// clamp regulator gain decode
	wire [1:0] p_sel = clamp_reg[P_SEL_LSB +: 2];
	wire [1:0] d_sel = clamp_reg[D_SEL_LSB +: 2];
	wire [2:0] i_sel = clamp_reg[I_SEL_LSB +: 3];

	wire [2:0]  next_p_shift = 3'h6 - {1'b0, p_sel};                      // [R4]
	wire [2:0]  next_d_fact  = {1'b0, d_sel} + 3'h1;                      // [R6]
	wire [12:0] next_i_div   = (i_sel == 3'h7) ? I_DIV_MAX :              // [R5]
		13'(I_DIV_MIN << i_sel);

	always_ff @(posedge MCLK) begin
		if (RST) begin
			CLAMP_P_SHIFT   <= 3'h6;
			CLAMP_D_FACTOR  <= 3'h1;
			CLAMP_I_DIVISOR <= I_DIV_MIN;
		end else begin
			CLAMP_P_SHIFT   <= next_p_shift;
			CLAMP_D_FACTOR  <= next_d_fact;
			CLAMP_I_DIVISOR <= next_i_div;
		end
	end
endmodule : llc_top
`default_nettype wire

/* testbench/llc_checker.sv */
/* llc_checker: properties on the llc_top ports.
 * Assumes a bind into llc_top, MCLK domain, synchronous RST. */
`timescale 1ns/1ps
`default_nettype none
module llc_checker
	import llc_pkg::*;
#(
	parameter int PHASE_W = 8
) (
	input wire logic               MCLK,
	input wire logic               RST,
	input wire logic               SDA_OUT,
	input wire logic               LINE_DONE,
	input wire logic [PHASE_W-1:0] PHASE_ERR,
	input wire logic               LINE_LOCKED,
	input wire logic               LOCK_GAINED,
	input wire logic               LOCK_LOST,
	input wire logic [2:0]         CLAMP_P_SHIFT,
	input wire logic [12:0]        CLAMP_I_DIVISOR,
	input wire logic [2:0]         CLAMP_D_FACTOR
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	property p_gain_pulse; LOCK_GAINED |=> !LOCK_GAINED; endproperty
	a_gain_pulse: assert property (p_gain_pulse) else $error("gain pulse long");
	property p_lost_pulse; LOCK_LOST |=> !LOCK_LOST; endproperty
	a_lost_pulse: assert property (p_lost_pulse) else $error("loss pulse long");
	property p_gain_state; LOCK_GAINED |-> LINE_LOCKED && !$past(LINE_LOCKED); endproperty
	a_gain_state: assert property (p_gain_state) else $error("gain without lock");
	property p_lost_state; LOCK_LOST |-> !LINE_LOCKED && $past(LINE_LOCKED); endproperty
	a_lost_state: assert property (p_lost_state) else $error("loss without unlock");
	property p_hold; !LOCK_GAINED && !LOCK_LOST |-> $stable(LINE_LOCKED); endproperty
	a_hold: assert property (p_hold) else $error("lock moved between runs");
	property p_gain_line; LOCK_GAINED |-> $past(LINE_DONE); endproperty
	a_gain_line: assert property (p_gain_line) else $error("gain without line");
	property p_lost_line; LOCK_LOST |-> $past(LINE_DONE); endproperty
	a_lost_line: assert property (p_lost_line) else $error("loss without line");
	property p_p_range; CLAMP_P_SHIFT inside {[3'h3:3'h6]}; endproperty
	a_p_range: assert property (p_p_range) else $error("bad p shift");
	property p_i_range;
		CLAMP_I_DIVISOR >= I_DIV_MIN && ($onehot(CLAMP_I_DIVISOR) || CLAMP_I_DIVISOR == I_DIV_MAX);
	endproperty
	a_i_range: assert property (p_i_range) else $error("bad i divisor");
	property p_d_range; CLAMP_D_FACTOR inside {[3'h1:3'h4]}; endproperty
	a_d_range: assert property (p_d_range) else $error("bad d factor");
	property p_lost_err; LOCK_LOST |-> $past(PHASE_ERR) != '0; endproperty
	a_lost_err: assert property (p_lost_err) else $error("loss on zero error");
	property p_sda_low; SDA_OUT == 1'b0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
endmodule : llc_checker
`default_nettype wire

/* testbench/llc_video_src.sv */
/* llc_video_src: line source, one line every four clocks while enabled.
 * Assumes en and err change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module llc_video_src (
	input  wire logic       clk,
	input  wire logic       en,
	input  wire logic [7:0] err,
	output var  logic       line_done,
	output var  logic [7:0] phase_err
);
	logic [1:0] cnt = 2'h0;
	initial begin
		line_done = 1'b0;
		phase_err = 8'h00;
	end
	// error only valid with the strobe, churns otherwise
	always @(negedge clk) begin
		cnt <= cnt + 2'h1;
		line_done <= en && cnt == 2'h3;
		phase_err <= (en && cnt == 2'h3) ? err : ~phase_err;
	end
endmodule : llc_video_src
`default_nettype wire

/* testbench/testbench.sv */
/* testbench: register, clamp and lock scenarios for llc_top.
 * Assumes a pulled-up bus data line and the line source model. */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import llc_pkg::*;
;
	logic        MCLK = 1'b0, RST = 1'b1, scl = 1'b1, sda_m = 1'b1, en = 1'b0, ack, g;
	logic [7:0]  err = 8'h00, q;
	int          num_errors = 0, samples_checked = 0;
	int          n_gain = 0, n_lost = 0;
	wire logic   oe, s_out, ld, locked, gained, lost;
	wire logic [7:0] pe;
	wire logic [2:0] p_sh, d_f;
	wire logic [12:0] i_div;
	wire logic   sda = sda_m & ~oe;
	always #10 MCLK = ~MCLK;
	always @(negedge MCLK) begin
		if (gained === 1'b1) begin
			n_gain++;
		end
		if (lost === 1'b1) begin
			n_lost++;
		end
	end
	llc_video_src src (.clk(MCLK), .en(en), .err(err), .line_done(ld), .phase_err(pe));
	llc_top DUT (.MCLK(MCLK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(s_out),
		.SDA_OE(oe), .LINE_DONE(ld), .PHASE_ERR(pe), .LINE_LOCKED(locked),
		.LOCK_GAINED(gained), .LOCK_LOST(lost), .CLAMP_P_SHIFT(p_sh),
		.CLAMP_I_DIVISOR(i_div), .CLAMP_D_FACTOR(d_f));
	task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] v);
		samples_checked++;
		if (v !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask : cmp
	task automatic hp;
		repeat (10) @(negedge MCLK);
	endtask : hp
	task automatic cond(input logic a, input logic b);
		repeat (3) @(negedge MCLK);
		sda_m = a;
		hp;
		scl = 1'b1;
		hp;
		sda_m = b;
		hp;
	endtask : cond
	task automatic bit_x(input logic b, output logic r);
		repeat (3) @(negedge MCLK);
		sda_m = b;
		hp;
		scl = 1'b1;
		hp;
		r = sda;
		scl = 1'b0;
	endtask : bit_x
	task automatic xbyte(input logic [7:0] d, input logic m);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(m, g);
		ack = !g;
	endtask : xbyte
	task automatic head(input logic [7:0] a);
		cond(1'b1, 1'b0);
		scl = 1'b0;
		xbyte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
		cmp("ack", 13'h0001, {12'h000, ack});
		xbyte(a, 1'b1);
	endtask : head
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		head(a);
		xbyte(d, 1'b1);
		cond(1'b0, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		head(a);
		cond(1'b1, 1'b0);
		scl = 1'b0;
		xbyte({DEV_ADDR_DEFAULT, 1'b1}, 1'b1);
		xbyte(8'hFF, 1'b1);
		cond(1'b0, 1'b1);
		cmp("read", {5'h00, e}, {5'h00, q});
	endtask : rd
	task automatic lines(input int n, input logic [7:0] e);
		err <= e;
		en <= 1'b1;
		repeat (n) begin
			@(posedge MCLK);
			while (ld !== 1'b1) @(posedge MCLK);
		end
		@(negedge MCLK);
		en <= 1'b0;
		repeat (3) @(negedge MCLK);
	endtask : lines
	task automatic ck_lock(input logic e);
		cmp("locked", {12'h000, e}, {12'h000, locked});
	endtask : ck_lock
	task automatic t_regs;
		logic [7:0] ofs [10] = '{OFS_TUNING_A, OFS_LOCK_RUNS, OFS_LIMIT, OFS_CLAMP,
			OFS_TUNING_B, OFS_TUNING_C, OFS_TUNING_D, OFS_TUNING_E, 8'h30, OFS_STATUS};
		logic [7:0] rv [10] = '{RST_TUNING_A, RST_LOCK_RUNS, RST_LIMIT, RST_CLAMP,
			RST_TUNING_B, RST_TUNING_C, RST_TUNING_D, RST_TUNING_E, 8'h00, 8'h00};
		cmp("p_shift", 13'h0004, {10'h000, p_sh});
		cmp("i_div", I_DIV_MIN << 2, i_div);
		cmp("d_factor", 13'h0001, {10'h000, d_f});
		ck_lock(1'b0);
		wr(OFS_TUNING_A, 8'h66);
		wr(OFS_TUNING_D, 8'h0A);
		for (int i = 0; i < 10; i++) begin
			rd(ofs[i], rv[i]);
		end
		cond(1'b1, 1'b0);
		scl = 1'b0;
		xbyte({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1);
		cmp("foreign ack", 13'h0000, {12'h000, ack});
		cond(1'b0, 1'b1);
	endtask : t_regs
	task automatic t_clamp;
		for (int p = 0; p < 4; p++) begin
			wr(OFS_CLAMP, {p[1:0], 3'h0, {3{p[0]}}});
			cmp("p_shift", 13'(6 - p), {10'h000, p_sh});
			cmp("i_div", p[0] ? I_DIV_MAX : I_DIV_MIN, i_div);
			cmp("d_factor", 13'h0001, {10'h000, d_f});
		end
	endtask : t_clamp
	task automatic t_lock;
		lines(7, 8'h00);
		lines(1, 8'h28);
		lines(7, 8'h27);
		ck_lock(1'b0);
		lines(1, 8'h27);
		ck_lock(1'b1);
		rd(OFS_STATUS, 8'h01);
		lines(31, 8'h29);
		lines(1, 8'h28);
		lines(31, 8'hFF);
		ck_lock(1'b1);
		lines(1, 8'h29);
		ck_lock(1'b0);
	endtask : t_lock
	task automatic t_fast;
		wr(OFS_LOCK_RUNS, 8'h11);
		wr(OFS_LIMIT, 8'h12);
		lines(3, 8'h0F);
		ck_lock(1'b0);
		lines(1, 8'h0F);
		ck_lock(1'b1);
		lines(3, 8'h11);
		ck_lock(1'b1);
		lines(1, 8'h11);
		ck_lock(1'b0);
		cmp("gains", 13'h0002, 13'(n_gain));
		cmp("losses", 13'h0002, 13'(n_lost));
	endtask : t_fast
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (8) @(negedge MCLK);
		RST = 1'b0;
		repeat (8) @(negedge MCLK);
		t_regs;
		t_clamp;
		t_lock;
		t_fast;
		close_out;
	end
	initial begin
		repeat (80000) @(posedge MCLK);
		num_errors++;
		close_out;
	end
endmodule : testbench
bind llc_top llc_checker #(.PHASE_W(PHASE_W)) u_chk (.*);
`default_nettype wire
